// File: hw/vle_pkg.sv
`default_nettype none
package vle_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int VCH_COUNT = 8;
  localparam int LCH_COUNT = 4;
  localparam int PCH_COUNT = 8;
  localparam int TCH_COUNT = 4;
  localparam int FB_OBJ_COUNT = 20;
  localparam logic [4:0] FB_COUNT = 5'h14;
  localparam logic [4:0] FB_BASE = 5'h08;
  localparam logic [3:0] VIN_MAX = 4'h8;
  localparam int SRC_COUNT = 24;
  localparam logic [1:0] NFUNC_MAX = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TICK_W = 19;
  localparam int SEC_MS = 1000;
  localparam logic [6:0] SEC_TICKS = 7'(SEC_MS / TICK_MS);
  localparam logic [15:0] VCNT_LAST = 16'h0001;
  localparam logic [7:0] PRESS_SAT = 8'hff;

  // ----------------------------------------------------------------
  // Register indices (word address on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_GLOBAL = 8'h00;
  localparam logic [7:0] REG_STAT_V = 8'h01;
  localparam logic [7:0] REG_STAT_L = 8'h02;
  localparam logic [7:0] REG_MASK_V = 8'h03;
  localparam logic [7:0] REG_MASK_L = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h05;
  localparam logic [7:0] REG_VCH_BASE = 8'h10;
  localparam logic [7:0] REG_LCFG_BASE = 8'h20;
  localparam logic [7:0] REG_LSRC_BASE = 8'h28;

  // Reset values
  localparam logic [7:0] SHORT_RST = 8'h05;
  localparam logic [7:0] LONG_RST = 8'h64;
  localparam logic [1:0] NFUNC_RST = 2'h1;

  // ----------------------------------------------------------------
  // Gate functions
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GATE_AND = 3'h0,
    GATE_NAND = 3'h1,
    GATE_OR = 3'h2,
    GATE_NOR = 3'h3,
    GATE_XOR = 3'h4,
    GATE_XNOR = 3'h5
  } vle_gate_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Event bits of one channel, also the status and mask layout
  typedef struct packed {
    logic long_p;
    logic short_p;
    logic fall_p;
    logic rise_p;
  } vle_ev_s;

  // Virtual channel configuration word: [24] pol, [20:16] src, [15:0] timeout
  typedef struct packed {
    logic pol;
    logic [4:0] src;
    logic [15:0] timeout;
  } vle_vcfg_s;

  // Logic channel word A: [27:25] f3 [24:22] f2 [21:19] f1 [18] pol
  // [17:16] nfunc [15:8] long [7:0] short
  typedef struct packed {
    logic [2:0] f3;
    logic [2:0] f2;
    logic [2:0] f1;
    logic pol;
    logic [1:0] nfunc;
    logic [7:0] long_n;
    logic [7:0] short_n;
  } vle_lcfg_s;

  // Logic channel word B: four 5-bit source selects, input 1 lowest
  typedef logic [3:0][4:0] vle_lsrc_t;

endpackage
`default_nettype wire

// File: hw/vle_press.sv
`timescale 1ns/10ps
`default_nettype none
module vle_press (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Channel state and timing
  input wire logic state,
  input wire logic tick,
  input wire logic [7:0] short_n,
  input wire logic [7:0] long_n,
  // Press events
  output logic short_p,
  output logic long_p
);

  logic prev_q;
  logic done_q;
  logic [7:0] cnt_q;

  // Press length in ticks, saturating so a stuck high cannot wrap
  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      prev_q <= state;
      if (state && !prev_q) begin
        cnt_q <= 8'h00;
      end else if (state && tick && cnt_q != vle_pkg::PRESS_SAT) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  // Long press once per high phase; short on release inside the window
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
      long_p <= 1'b0;
      short_p <= 1'b0;
    end else begin
      long_p <= 1'b0;
      short_p <= 1'b0;
      if (state && !prev_q) begin
        done_q <= 1'b0;
      end else if (state && !done_q && cnt_q >= long_n) begin
        long_p <= 1'b1;
        done_q <= 1'b1;
      end
      if (!state && prev_q) begin
        short_p <= !done_q && cnt_q >= short_n;
      end
    end
  end

  sequence s_release;
    !state && prev_q;
  endsequence

  chk_short_window: assert property (@(posedge mclk) disable iff (rst)
    s_release ##1 short_p |-> $past(cnt_q) >= $past(short_n) && !$past(done_q))
    else $error("short press outside its window");

  chk_long_held: assert property (@(posedge mclk) disable iff (rst)
    long_p |-> $past(state) && $past(cnt_q) >= $past(long_n))
    else $error("long press without a held state");

endmodule // vle_press
`default_nettype wire

// File: hw/vle_events.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Virtual state is object value xor polarity
// - Every telegram to source gives short press
// - Telegram restarts timeout; expiry gives long press
// - Timeout 0..65535 s; zero disables long press
// - Object value edges give rise and fall
// - Virtual source is one single-bit object only
// - One to three gate functions, default one
// - Gates: AND NAND OR NOR XOR XNOR
// - Inputs select physical, virtual, logic or timer
// - Gates use channel states, not events
// - Logic state is result xor polarity
// - Result edges give rise and fall
// - Short press: release between short and long
// - Long threshold n ticks, default 100
// - Long press when held to threshold
// - Only enabled virtual inputs accept telegrams
module vle_events #(
  parameter int TICK_CYC = vle_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Telegrams to general virtual inputs
  input wire logic tg_valid,
  input wire logic [2:0] tg_index,
  input wire logic tg_value,
  // Writes to single-bit function block objects
  input wire logic fb_valid,
  input wire logic [4:0] fb_index,
  input wire logic fb_value,
  // States of the other channel groups
  input wire logic [7:0] phys_state,
  input wire logic [3:0] timer_state,
  // Channel states and events
  output logic [7:0] vch_state,
  output logic [3:0] lch_state,
  output vle_pkg::vle_ev_s [7:0] vch_ev,
  output vle_pkg::vle_ev_s [3:0] lch_ev,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Unknown op codes fall back to AND
  function automatic logic gate_fn(input logic [2:0] op, input logic a, input logic b);
    case (op)
      vle_pkg::GATE_NAND: gate_fn = !(a && b);
      vle_pkg::GATE_OR: gate_fn = a || b;
      vle_pkg::GATE_NOR: gate_fn = !(a || b);
      vle_pkg::GATE_XOR: gate_fn = a ^ b;
      vle_pkg::GATE_XNOR: gate_fn = !(a ^ b);
      default: gate_fn = a && b;
    endcase
  endfunction

  // Value of a selected single-bit object; out of range reads zero
  function automatic logic obj_sel(input logic [4:0] src, input logic [7:0] vin,
                                   input logic [19:0] fb);
    logic [4:0] k;
    k = src - vle_pkg::FB_BASE;
    if (src < vle_pkg::FB_BASE) begin
      obj_sel = vin[src[2:0]];
    end else if (k < vle_pkg::FB_COUNT) begin
      obj_sel = fb[k];
    end else begin
      obj_sel = 1'b0;
    end
  endfunction

  // Whether an accepted write this cycle targets the selected object
  function automatic logic obj_hit(input logic [4:0] src, input logic tg_ok,
                                   input logic [2:0] tg_i, input logic fb_ok,
                                   input logic [4:0] fb_i);
    if (src < vle_pkg::FB_BASE) begin
      obj_hit = tg_ok && tg_i == src[2:0];
    end else begin
      obj_hit = fb_ok && fb_i == 5'(src - vle_pkg::FB_BASE);
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0] num_vin_q;
  vle_pkg::vle_vcfg_s vcfg_q [vle_pkg::VCH_COUNT];
  vle_pkg::vle_lcfg_s lcfg_q [vle_pkg::LCH_COUNT];
  vle_pkg::vle_lsrc_t lsrc_q [vle_pkg::LCH_COUNT];
  logic [31:0] mask_v_q;
  logic [15:0] mask_l_q;
  logic [31:0] stat_v_q;
  logic [15:0] stat_l_q;

  logic [7:0] woff;
  assign woff = reg_addr - vle_pkg::REG_VCH_BASE;
  logic [7:0] loff;
  assign loff = reg_addr - vle_pkg::REG_LCFG_BASE;
  logic [7:0] soff;
  assign soff = reg_addr - vle_pkg::REG_LSRC_BASE;

  // Software writes; counts above their limits are clamped
  always_ff @(posedge mclk) begin
    if (rst) begin
      num_vin_q <= 4'h0;
      mask_v_q <= 32'h0000_0000;
      mask_l_q <= 16'h0000;
      for (int i = 0; i < vle_pkg::VCH_COUNT; i++) begin
        vcfg_q[i] <= '0;
      end
      for (int i = 0; i < vle_pkg::LCH_COUNT; i++) begin
        lcfg_q[i] <= '{f3: 3'h0, f2: 3'h0, f1: 3'h0, pol: 1'b0,
                       nfunc: vle_pkg::NFUNC_RST, long_n: vle_pkg::LONG_RST,
                       short_n: vle_pkg::SHORT_RST};
        lsrc_q[i] <= '0;
      end
    end else if (reg_wr) begin
      if (reg_addr == vle_pkg::REG_GLOBAL) begin
        num_vin_q <= (reg_wdata[3:0] > vle_pkg::VIN_MAX) ? vle_pkg::VIN_MAX
                                                         : reg_wdata[3:0];
      end
      if (reg_addr == vle_pkg::REG_MASK_V) begin
        mask_v_q <= reg_wdata;
      end
      if (reg_addr == vle_pkg::REG_MASK_L) begin
        mask_l_q <= reg_wdata[15:0];
      end
      if (woff < 8'(vle_pkg::VCH_COUNT)) begin
        vcfg_q[woff[2:0]] <= '{pol: reg_wdata[24], src: reg_wdata[20:16],
                               timeout: reg_wdata[15:0]};
      end
      if (loff < 8'(vle_pkg::LCH_COUNT)) begin
        lcfg_q[loff[1:0]] <= reg_wdata[27:0];
        if (reg_wdata[17:16] == 2'h0) begin
          lcfg_q[loff[1:0]].nfunc <= vle_pkg::NFUNC_RST;
        end
      end
      if (soff < 8'(vle_pkg::LCH_COUNT)) begin
        lsrc_q[soff[1:0]] <= reg_wdata[19:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Ticks
  // ----------------------------------------------------------------
  localparam logic [vle_pkg::TICK_W-1:0] TICK_LAST = vle_pkg::TICK_W'(TICK_CYC - 1);
  logic [vle_pkg::TICK_W-1:0] tick_cnt_q;
  logic [6:0] sec_cnt_q;
  logic tick;
  logic sec_tick;
  assign tick = tick_cnt_q == TICK_LAST;
  assign sec_tick = tick && sec_cnt_q == 7'(vle_pkg::SEC_TICKS - 7'h01);

  // Free-running divider; the first period after a restart is partial
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt_q <= '0;
      sec_cnt_q <= 7'h00;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
      if (sec_tick) begin
        sec_cnt_q <= 7'h00;
      end else if (tick) begin
        sec_cnt_q <= sec_cnt_q + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Object store
  // ----------------------------------------------------------------
  logic tg_ok;
  logic fb_ok;
  logic [7:0] vin_q;
  logic [19:0] fb_q;
  assign tg_ok = tg_valid && {1'b0, tg_index} < num_vin_q;
  assign fb_ok = fb_valid && fb_index < vle_pkg::FB_COUNT;

  // Disabled inputs drop their telegrams without a trace
  always_ff @(posedge mclk) begin
    if (rst) begin
      vin_q <= 8'h00;
      fb_q <= 20'h00000;
    end else begin
      if (tg_ok) begin
        vin_q[tg_index] <= tg_value;
      end
      if (fb_ok) begin
        fb_q[fb_index] <= fb_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Virtual channels
  // ----------------------------------------------------------------
  logic [7:0] vobj_d;
  logic [7:0] vobj_q;
  logic [7:0] vhit;
  logic [7:0] vlong;
  logic [15:0] vcnt_q [vle_pkg::VCH_COUNT];
  logic [7:0] varm_q;

  // Object selection and telegram hits per channel
  always_comb begin
    for (int i = 0; i < vle_pkg::VCH_COUNT; i++) begin
      vobj_d[i] = obj_sel(vcfg_q[i].src, vin_q, fb_q);
      vhit[i] = obj_hit(vcfg_q[i].src, tg_ok, tg_index, fb_ok, fb_index);
      vlong[i] = !vhit[i] && sec_tick && varm_q[i] && vcnt_q[i] == vle_pkg::VCNT_LAST;
      vch_state[i] = vobj_q[i] ^ vcfg_q[i].pol;
    end
  end

  // Inactivity timer in seconds; a telegram always reloads it
  always_ff @(posedge mclk) begin
    if (rst) begin
      varm_q <= 8'h00;
      for (int i = 0; i < vle_pkg::VCH_COUNT; i++) begin
        vcnt_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < vle_pkg::VCH_COUNT; i++) begin
        if (vhit[i]) begin
          vcnt_q[i] <= vcfg_q[i].timeout;
          varm_q[i] <= vcfg_q[i].timeout != 16'h0000;
        end else if (sec_tick && varm_q[i]) begin
          vcnt_q[i] <= vcnt_q[i] - 16'h0001;
          varm_q[i] <= vcnt_q[i] != vle_pkg::VCNT_LAST;
        end
      end
    end
  end

  // Registered events; edges follow the object value itself
  always_ff @(posedge mclk) begin
    if (rst) begin
      vobj_q <= 8'h00;
      vch_ev <= '0;
    end else begin
      vobj_q <= vobj_d;
      for (int i = 0; i < vle_pkg::VCH_COUNT; i++) begin
        vch_ev[i].rise_p <= vobj_d[i] && !vobj_q[i];
        vch_ev[i].fall_p <= !vobj_d[i] && vobj_q[i];
        vch_ev[i].short_p <= vhit[i];
        vch_ev[i].long_p <= vlong[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Logic channels
  // ----------------------------------------------------------------
  logic [vle_pkg::SRC_COUNT-1:0] src_vec;
  logic [3:0] lres_d;
  logic [3:0] lres_q;
  logic [3:0] lshort;
  logic [3:0] llong;
  logic [3:0] lrise_q;
  logic [3:0] lfall_q;

  // Registered logic states feed back so chains cannot loop
  assign src_vec = {timer_state, lch_state, vch_state, phys_state};

  // Gate chain per channel; later gates only count when selected
  always_comb begin
    for (int i = 0; i < vle_pkg::LCH_COUNT; i++) begin
      logic [3:0] in;
      logic r;
      in = 4'h0;
      for (int j = 0; j < 4; j++) begin
        in[j] = (lsrc_q[i][j] < 5'(vle_pkg::SRC_COUNT)) ? src_vec[lsrc_q[i][j]] : 1'b0;
      end
      r = gate_fn(lcfg_q[i].f1, in[0], in[1]);
      if (lcfg_q[i].nfunc >= 2'h2) begin
        r = gate_fn(lcfg_q[i].f2, r, in[2]);
      end
      if (lcfg_q[i].nfunc >= vle_pkg::NFUNC_MAX) begin
        r = gate_fn(lcfg_q[i].f3, r, in[3]);
      end
      lres_d[i] = r;
    end
  end

  // Result, state and edge events, one clock behind the sources
  always_ff @(posedge mclk) begin
    if (rst) begin
      lres_q <= 4'h0;
      lch_state <= 4'h0;
      lrise_q <= 4'h0;
      lfall_q <= 4'h0;
    end else begin
      lres_q <= lres_d;
      for (int i = 0; i < vle_pkg::LCH_COUNT; i++) begin
        lch_state[i] <= lres_d[i] ^ lcfg_q[i].pol;
        lrise_q[i] <= lres_d[i] && !lres_q[i];
        lfall_q[i] <= !lres_d[i] && lres_q[i];
      end
    end
  end

  // Press timing on the logic state, one detector per channel
  for (genvar g = 0; g < vle_pkg::LCH_COUNT; g++) begin : g_press
    vle_press u_press (
      .mclk(mclk),
      .rst(rst),
      .state(lch_state[g]),
      .tick(tick),
      .short_n(lcfg_q[g].short_n),
      .long_n(lcfg_q[g].long_n),
      .short_p(lshort[g]),
      .long_p(llong[g])
    );
    // One driver for the whole event word of each logic channel
    assign lch_ev[g] = '{long_p: llong[g], short_p: lshort[g],
                         fall_p: lfall_q[g], rise_p: lrise_q[g]};
  end

  // ----------------------------------------------------------------
  // Interrupt status and read port
  // ----------------------------------------------------------------
  logic [31:0] clr_v;
  logic [15:0] clr_l;
  assign clr_v = (reg_wr && reg_addr == vle_pkg::REG_STAT_V) ? reg_wdata : 32'h0000_0000;
  assign clr_l = (reg_wr && reg_addr == vle_pkg::REG_STAT_L) ? reg_wdata[15:0] : 16'h0000;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_v_q <= 32'h0000_0000;
      stat_l_q <= 16'h0000;
    end else begin
      stat_v_q <= (stat_v_q & ~clr_v) | vch_ev;
      stat_l_q <= (stat_l_q & ~clr_l) | lch_ev;
    end
  end

  assign irq = |(stat_v_q & mask_v_q) || |(stat_l_q & mask_l_q);

  // Read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == vle_pkg::REG_GLOBAL) begin
          reg_rdata <= 32'(num_vin_q);
        end else if (reg_addr == vle_pkg::REG_STAT_V) begin
          reg_rdata <= stat_v_q;
        end else if (reg_addr == vle_pkg::REG_STAT_L) begin
          reg_rdata <= 32'(stat_l_q);
        end else if (reg_addr == vle_pkg::REG_MASK_V) begin
          reg_rdata <= mask_v_q;
        end else if (reg_addr == vle_pkg::REG_MASK_L) begin
          reg_rdata <= 32'(mask_l_q);
        end else if (reg_addr == vle_pkg::REG_STATE) begin
          reg_rdata <= {20'h00000, lch_state, vch_state};
        end else if (woff < 8'(vle_pkg::VCH_COUNT)) begin
          reg_rdata <= {7'h00, vcfg_q[woff[2:0]].pol, 3'h0, vcfg_q[woff[2:0]].src,
                        vcfg_q[woff[2:0]].timeout};
        end else if (loff < 8'(vle_pkg::LCH_COUNT)) begin
          reg_rdata <= 32'(lcfg_q[loff[1:0]]);
        end else if (soff < 8'(vle_pkg::LCH_COUNT)) begin
          reg_rdata <= 32'(lsrc_q[soff[1:0]]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_tg_short: assert property (@(posedge mclk) disable iff (rst)
    vhit[0] |=> vch_ev[0].short_p)
    else $error("telegram gave no short press");

  chk_vin_gate: assert property (@(posedge mclk) disable iff (rst)
    tg_valid && {1'b0, tg_index} >= num_vin_q && !fb_valid |=> $stable(vin_q))
    else $error("disabled virtual input took a telegram");

  chk_vto_zero: assert property (@(posedge mclk) disable iff (rst)
    vhit[0] && vcfg_q[0].timeout == 16'h0000 |=> !varm_q[0])
    else $error("zero timeout armed the timer");

  chk_vto_reload: assert property (@(posedge mclk) disable iff (rst)
    vhit[0] && vcfg_q[0].timeout != 16'h0000
    |=> varm_q[0] && vcnt_q[0] == $past(vcfg_q[0].timeout))
    else $error("telegram did not restart the timer");

  chk_vlong_expiry: assert property (@(posedge mclk) disable iff (rst)
    vch_ev[0].long_p |-> $past(sec_tick) && $past(vcnt_q[0]) == vle_pkg::VCNT_LAST
    && !varm_q[0])
    else $error("long press without timer expiry");

  chk_vedge_rise: assert property (@(posedge mclk) disable iff (rst)
    $rose(vobj_q[0]) |-> vch_ev[0].rise_p && !vch_ev[0].fall_p)
    else $error("object rise gave no rising edge");

  chk_lch_pol: assert property (@(posedge mclk) disable iff (rst)
    $stable(lcfg_q[0].pol) |-> lch_state[0] == (lres_q[0] ^ lcfg_q[0].pol))
    else $error("logic state disagrees with result and polarity");

  chk_ledge_fall: assert property (@(posedge mclk) disable iff (rst)
    $fell(lres_q[0]) |-> lch_ev[0].fall_p && !lch_ev[0].rise_p)
    else $error("result fall gave no falling edge");

  chk_irq_level: assert property (@(posedge mclk) disable iff (rst)
    vch_ev[0].short_p && mask_v_q[2] |=> irq)
    else $error("unmasked event raised no interrupt");

endmodule // vle_events
`default_nettype wire

// File: dv/vle_far.sv
`timescale 1ns/10ps
`default_nettype none
// Far side: telegram receiver, function block objects and other channel states
module vle_far (
  // Clock
  input wire logic mclk,
  // Telegrams and object writes
  output logic tg_valid,
  output logic [2:0] tg_index,
  output logic tg_value,
  output logic fb_valid,
  output logic [4:0] fb_index,
  output logic fb_value,
  // Other channel states
  output logic [7:0] phys_state,
  output logic [3:0] timer_state
);
  // Quiet bus at time zero
  initial begin
    tg_valid = 1'b0;
    tg_index = 3'h0;
    tg_value = 1'b0;
    fb_valid = 1'b0;
    fb_index = 5'h00;
    fb_value = 1'b0;
    phys_state = 8'h00;
    timer_state = 4'h0;
  end
  // One-cycle telegram; lines show the inverse afterwards so stale data is never reused
  task automatic send_tg(input logic [2:0] idx, input logic val);
    @(posedge mclk);
    tg_valid <= 1'b1;
    tg_index <= idx;
    tg_value <= val;
    @(posedge mclk);
    tg_valid <= 1'b0;
    tg_index <= ~idx;
    tg_value <= ~val;
  endtask
  // One-cycle object write from a function block
  task automatic send_fb(input logic [4:0] idx, input logic val);
    @(posedge mclk);
    fb_valid <= 1'b1;
    fb_index <= idx;
    fb_value <= val;
    @(posedge mclk);
    fb_valid <= 1'b0;
    fb_index <= ~idx;
    fb_value <= ~val;
  endtask
  // Level states of the physical and timer channels
  task automatic set_in(input logic [7:0] p, input logic [3:0] t);
    @(posedge mclk);
    phys_state <= p;
    timer_state <= t;
  endtask
endmodule // vle_far
`default_nettype wire

// File: dv/vle_events_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vle_events_tb;
  logic mclk, rst, reg_wr, reg_rd, tg_valid, tg_value, fb_valid, fb_value, irq;
  logic [7:0] reg_addr, phys_state, vch_state;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0] tg_index;
  logic [4:0] fb_index;
  logic [3:0] timer_state, lch_state;
  vle_pkg::vle_ev_s [7:0] vch_ev;
  vle_pkg::vle_ev_s [3:0] lch_ev;
  int n_fail = 0;
  int samples_checked = 0;
  int cnt [48];
  int c_s, c_l, c_r;
  logic [47:0] evs;
  assign evs = {lch_ev, vch_ev};
  // Short tick so that one second is 1000 cycles
  vle_events #(.TICK_CYC(10)) DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tg_valid(tg_valid), .tg_index(tg_index), .tg_value(tg_value), .fb_valid(fb_valid),
    .fb_index(fb_index), .fb_value(fb_value), .phys_state(phys_state),
    .timer_state(timer_state), .vch_state(vch_state), .lch_state(lch_state),
    .vch_ev(vch_ev), .lch_ev(lch_ev), .irq(irq));
  vle_far u_far (.mclk(mclk), .tg_valid(tg_valid), .tg_index(tg_index), .tg_value(tg_value),
    .fb_valid(fb_valid), .fb_index(fb_index), .fb_value(fb_value),
    .phys_state(phys_state), .timer_state(timer_state));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Event pulse counters: virtual 4c+b, logic 32+4c+b (rise, fall, short, long)
  always @(posedge mclk) begin
    for (int i = 0; i < 48; i++) begin
      cnt[i] <= cnt[i] + int'(evs[i]);
    end
  end
  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Bounded wait for one more pulse on counter k; running out ends the run
  task automatic wait_ev(input int k, input int lim);
    int c0;
    c0 = cnt[k];
    for (int i = 0; i < lim && cnt[k] == c0; i++) @(posedge mclk);
    chk("event_wait", 32'(cnt[k] - c0), 32'h1);
    if (cnt[k] == c0) stop_test();
  endtask
  // Reference gate: pairs of codes share a base function, odd codes invert it
  function automatic logic gate(input int g, input logic a, input logic b);
    logic r;
    r = (g < 2) ? (a & b) : (g < 4) ? (a | b) : (a ^ b);
    return r ^ g[0];
  endfunction
  // Main sequence
  initial begin
    for (int i = 0; i < 48; i++) cnt[i] = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(vle_pkg::REG_LCFG_BASE, d);
    chk("lcfg_reset", d, 32'h0001_6405);
    rd(8'h3f, d);
    chk("unmapped", d, 32'h0000_0000);
    wr(vle_pkg::REG_GLOBAL, 32'h0000_000f);
    rd(vle_pkg::REG_GLOBAL, d);
    chk("num_vin", d, 32'h0000_0008);
    wr(vle_pkg::REG_GLOBAL, 32'h0000_0001);
    wr(8'h10, 32'h0000_0001); // Input A, one second timeout
    wr(8'h11, 32'h0100_0000); // Input A, inverted, timeout off
    wr(8'h12, 32'h0008_0000); // Function block object 0
    wr(8'h13, 32'h0001_0000); // Input B, which stays disabled
    wr(vle_pkg::REG_MASK_V, 32'h0000_0004);
    u_far.send_tg(3'h0, 1'b1);
    #1 chk("v0_short", 32'(vch_ev[0].short_p), 32'h1);
    @(posedge mclk);
    #1 chk("v0_rise", 32'(vch_ev[0].rise_p), 32'h1);
    chk("v_state", 32'(vch_state[1:0]), 32'h1);
    u_far.send_tg(3'h0, 1'b1);
    u_far.send_tg(3'h1, 1'b1);
    repeat (4) @(posedge mclk);
    chk("v0_shorts", 32'(cnt[2]), 32'h2);
    chk("v0_rises", 32'(cnt[0]), 32'h1);
    chk("v3_off", 32'(cnt[14]), 32'h0);
    chk("irq_set", 32'(irq), 32'h1);
    wr(vle_pkg::REG_STAT_V, 32'hffff_ffff);
    #1 chk("irq_clr", 32'(irq), 32'h0);
    u_far.send_fb(5'h00, 1'b1);
    repeat (4) @(posedge mclk);
    chk("fb_short", 32'(cnt[10]), 32'h1);
    chk("fb_state", 32'(vch_state[2]), 32'h1);
    u_far.send_tg(3'h0, 1'b0);
    wait_ev(3, 1010);
    chk("v0_fall", 32'(cnt[1]), 32'h1);
    chk("v1_nolong", 32'(cnt[7]), 32'h0);
    // Logic channel 0: in1 phys A, in2 phys B, in3 timer A
    wr(vle_pkg::REG_LSRC_BASE, 32'h0000_5020);
    for (int g = 0; g < 6; g++) begin
      wr(vle_pkg::REG_LCFG_BASE, {4'h0, 6'h00, 3'(g), 1'b0, 2'h1, 16'h0402});
      for (int ab = 0; ab < 4; ab++) begin
        u_far.set_in(8'(ab), 4'h0);
        repeat (2) @(posedge mclk);
        #1 chk("gate", 32'(lch_state[0]), 32'(gate(g, ab[0], ab[1])));
      end
    end
    wr(vle_pkg::REG_LCFG_BASE, 32'h0102_0402); // AND then XOR with timer A
    u_far.set_in(8'h03, 4'h1);
    repeat (2) @(posedge mclk);
    #1 chk("chain_a", 32'(lch_state[0]), 32'h0);
    u_far.set_in(8'h03, 4'h0);
    repeat (2) @(posedge mclk);
    #1 chk("chain_b", 32'(lch_state[0]), 32'h1);
    wr(vle_pkg::REG_LCFG_BASE, 32'h0106_0402);
    @(posedge mclk);
    #1 chk("chain_pol", 32'(lch_state[0]), 32'h0);
    // Press timing: short 2 ticks, long 4 ticks of 10 cycles
    wr(vle_pkg::REG_LCFG_BASE, 32'h0001_0402);
    u_far.set_in(8'h00, 4'h0);
    repeat (4) @(posedge mclk);
    c_s = cnt[34];
    c_l = cnt[35];
    c_r = cnt[32];
    u_far.set_in(8'h03, 4'h0);
    repeat (25) @(posedge mclk);
    u_far.set_in(8'h00, 4'h0);
    repeat (5) @(posedge mclk);
    chk("l_short", 32'(cnt[34] - c_s), 32'h1);
    chk("l_nolong", 32'(cnt[35] - c_l), 32'h0);
    chk("l_rise", 32'(cnt[32] - c_r), 32'h1);
    u_far.set_in(8'h03, 4'h0);
    wait_ev(35, 60);
    u_far.set_in(8'h00, 4'h0);
    repeat (5) @(posedge mclk);
    chk("l_noshort", 32'(cnt[34] - c_s), 32'h1);
    stop_test();
  end
endmodule // vle_events_tb
`default_nettype wire
